// File: src/lcs_pkg.sv
// package of offsets, field positions, reset values and timing for the laser channel safety control
package lcs_pkg;
  // register offsets (6-bit register address space)
  localparam logic [5:0] ADDR_FAULT_STATUS_A = 6'h00;
  localparam logic [5:0] ADDR_CHANNEL_STATUS_B = 6'h01;
  localparam logic [5:0] ADDR_CH1_CTRL = 6'h13;
  localparam logic [5:0] ADDR_CH2_CTRL = 6'h18;
  localparam logic [5:0] ADDR_COMBINE = 6'h1b;
  localparam logic [5:0] ADDR_MASKS = 6'h1d;
  localparam logic [5:0] ADDR_RANGE = 6'h1e;
  // fault_status_a bit positions
  localparam int FA_RAM_READY = 0;
  localparam int FA_MAIN_DROPOUT = 1;
  localparam int FA_RAM_CHECK = 2;
  localparam int FA_OVERHEAT = 3;
  localparam int FA_CH2_OVC = 4;
  localparam int FA_CH1_OVC = 5;
  localparam int FA_OSC = 6;
  localparam int FA_SETUP_TIMEOUT = 7;
  // channel_status_b bit positions, channel 2 sits CH_STRIDE higher
  localparam int CB_LOOP_STATE = 0;
  localparam int CB_MONITOR_SEEN = 1;
  localparam int CB_HEADROOM = 2;
  localparam int CB_SUPPLY_DROPOUT = 3;
  localparam int CH_STRIDE = 4;
  // control register fields (0x13 / 0x18)
  localparam int CTRL_HEADROOM_LSB = 2;
  localparam int CTRL_PULSE = 7;
  // combine bit at 0x1b
  localparam int COMBINE_BIT = 6;
  // mask register fields at 0x1d
  localparam int MASK_OSC = 0;
  localparam int MASK_CH1_HEADROOM = 2;
  localparam int MASK_CH2_HEADROOM = 3;
  // range fields at 0x1e
  localparam int RANGE_CH1_LSB = 0;
  localparam int RANGE_CH2_LSB = 4;
  // reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_COMBINE = 8'h00;
  localparam logic [7:0] RST_MASKS = 8'h0c;
  localparam logic [7:0] RST_RANGE = 8'h00;
  localparam logic [1:0] RST_OFF_BITS = 2'h3;
  localparam logic [7:0] RST_FAULT_A = 8'h03;
  localparam logic [7:0] RST_CHAN_B = 8'h88;
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int APC_PAUSE_US = 300;
  // pause length in cycles
  localparam int APC_PAUSE_CYCLES = APC_PAUSE_US * (CLK_HZ / 1_000_000);
  localparam int PULSE_MAX_KHZ = 300;
endpackage

// File: src/lcs_sync.sv
// two-flop synchroniser for a bank of asynchronous level inputs
`timescale 1ns/100ps
module lcs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // first stage is read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // ==========
  // two stages, nothing taps the first
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// File: src/lcs_pause_timer.sv
// pause-length timer that drops pulsed optical power loop regulation after a long gate-off
`timescale 1ns/100ps
module lcs_pause_timer #(
  parameter int PAUSE_CYCLES = lcs_pkg::APC_PAUSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic armed,
  input wire logic gate_on,
  output logic timed_out
);
  localparam int CW = $clog2(PAUSE_CYCLES + 1);
  logic [CW-1:0] count_r;
  logic [CW-1:0] count_nxt;
  logic hit;

  // refused at elaboration
  if (PAUSE_CYCLES < 1)
  begin : g_bad_pause
    $error("pause length must be at least one cycle");
  end

  // ==========
  // counting only while armed and gated off; saturates at the limit
  assign hit = (count_r == CW'(PAUSE_CYCLES));
  assign count_nxt = (!armed || gate_on) ? '0 : (hit ? count_r : count_r + 1'b1);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      count_r <= '0;
    else
      count_r <= count_nxt;
  end

  // timeout holds until the gate comes back on or the mode leaves
  assign timed_out = hit;
endmodule

// File: src/lcs_top.sv
// laser channel safety control top: flags, masks, gating, combine, range
//
// Summary of operation
// - two-bit headroom code per channel to comparator
// - headroom alarm sets status, pin unless masked
// - oscillator fault reaches pin unless masked
// - headroom alarm masks reset to one
// - open select or mode pin disables both
// - off bit resets one, keeps channel off
// - pending status errors disable channels
// - status changes signalled unless individually masked; live loop state bits never signal
// - fault_status_a bit layout at 0x00
// - channel_status_b bit layout at 0x01
// - status read acknowledges its reported errors
// - power-on sets dropout and ram flags
// - standby exit sets main dropout flag
// - overcurrent, heat, ram, timeout force off
// - pulse enable bit seven, resets zero
// - pulsed mode: gate pin switches current
// - pulsed power loop pause timeout, none for current loop
// - pulsed mode suppresses overcurrent in some cases
// - linear reference curve disables overcurrent
// - combine parallels channel 2, regulates channel 1
// - range fields, combined ranges add
// - supply dropout clear on read, mismatch in combine
// - oscillator failure sets flag and signals
`timescale 1ns/100ps
module lcs_top #(
  parameter int PAUSE_CYCLES = lcs_pkg::APC_PAUSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  // register port from the serial engine
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // asynchronous comparator and pin-state inputs
  input wire logic [1:0] headroom_cmp,
  input wire logic [1:0] overcurrent_cmp,
  input wire logic overheat_cmp,
  input wire logic main_supply_low,
  input wire logic [1:0] channel_supply_low,
  input wire logic supply_mismatch,
  input wire logic osc_watchdog_fail,
  input wire logic interface_pin_open_fault,
  input wire logic mode_pin_open_fault,
  input wire logic [1:0] channel_gate_pin,
  // same-domain events from neighbouring logic
  input wire logic ram_check_fault,
  input wire logic setup_timeout,
  input wire logic standby_exit,
  input wire logic [1:0] loop_state_in,
  input wire logic [1:0] monitor_enabled,
  // fields owned elsewhere in the register map
  input wire logic [1:0] current_loop_select,
  input wire logic [1:0] ch_limit_zero,
  input wire logic [1:0] reference_curve_select,
  input wire logic [1:0] simulate_overcurrent,
  // outputs
  output logic fault_out_pin_n,
  output logic [1:0] ch1_headroom_select,
  output logic [1:0] ch2_headroom_select,
  output logic [1:0] laser_enable,
  output logic [1:0] current_on,
  output logic [1:0] regulation_hold,
  output logic [1:0] overcurrent_active,
  output logic channel_combine,
  output logic [1:0] ch1_range_factor,
  output logic [1:0] ch2_range_factor,
  output logic [2:0] combined_range_sel
);
  // ==========
  // configuration and status registers
  logic [7:0] ch_ctrl_r [2];       // per-channel control, 0x13 and 0x18
  logic [7:0] combine_r;           // combine register
  logic [7:0] masks_r;             // error mask register
  logic [7:0] range_r;             // range register
  logic [1:0] off_bits_r;          // channel off bits
  logic [7:0] fault_a_r;           // fault_status_a
  logic [7:0] chan_b_r;            // channel_status_b
  logic fault_pin_r;               // registered error pin level (high = error)
  logic [1:0] pulse_enable;
  logic [1:0] apc_timeout;

  // ==========
  // synchronisers for asynchronous inputs
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] async_bus;
  logic [NSYNC-1:0] sync_bus;
  assign async_bus = {channel_gate_pin, mode_pin_open_fault, interface_pin_open_fault, osc_watchdog_fail,
                      supply_mismatch, channel_supply_low, main_supply_low, overheat_cmp, overcurrent_cmp,
                      headroom_cmp};

  lcs_sync #(.WIDTH(NSYNC)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(async_bus),
    .sync_out(sync_bus)
  );

  logic [1:0] s_headroom;
  logic [1:0] s_ovc;
  logic s_heat;
  logic s_main_low;
  logic [1:0] s_ch_low;
  logic s_mismatch;
  logic s_osc;
  logic s_ins_open;
  logic s_mode_open;
  logic [1:0] s_gate;
  assign s_headroom = sync_bus[1:0];
  assign s_ovc = sync_bus[3:2];
  assign s_heat = sync_bus[4];
  assign s_main_low = sync_bus[5];
  assign s_ch_low = sync_bus[7:6];
  assign s_mismatch = sync_bus[8];
  assign s_osc = sync_bus[9];
  assign s_ins_open = sync_bus[10];
  assign s_mode_open = sync_bus[11];
  assign s_gate = sync_bus[13:12];

  // ==========
  // address decode
  logic hit_a;
  logic hit_b;
  logic hit_c1;
  logic hit_c2;
  logic hit_comb;
  logic hit_mask;
  logic hit_rng;
  logic read_a;
  logic read_b;
  assign hit_a = (reg_addr == lcs_pkg::ADDR_FAULT_STATUS_A);
  assign hit_b = (reg_addr == lcs_pkg::ADDR_CHANNEL_STATUS_B);
  assign hit_c1 = (reg_addr == lcs_pkg::ADDR_CH1_CTRL);
  assign hit_c2 = (reg_addr == lcs_pkg::ADDR_CH2_CTRL);
  assign hit_comb = (reg_addr == lcs_pkg::ADDR_COMBINE);
  assign hit_mask = (reg_addr == lcs_pkg::ADDR_MASKS);
  assign hit_rng = (reg_addr == lcs_pkg::ADDR_RANGE);
  assign read_a = reg_rd && hit_a;  // acknowledges fault_status_a
  assign read_b = reg_rd && hit_b;  // acknowledges channel_status_b

  // ==========
  // overcurrent qualification per channel
  logic [1:0] ovc_event;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_ovc
      // pulsed: current loop or zero limit disables detection
      // linear reference curve disables detection
      assign overcurrent_active[gi] = !reference_curve_select[gi] &&
                                      !(pulse_enable[gi] && (current_loop_select[gi] || ch_limit_zero[gi]));
      assign ovc_event[gi] = (s_ovc[gi] && overcurrent_active[gi]) || simulate_overcurrent[gi];
    end
  endgenerate

  // ==========
  // status event vectors; set wins over read-clear
  logic [7:0] set_a;
  logic [7:0] set_b;
  logic [7:0] keep_b;
  logic [7:0] next_a;
  logic [7:0] next_b;
  logic ch2_supply_evt;
  logic ch1_supply_evt;
  // in combine, ch1 flag watches both supplies, ch2 flag the mismatch
  assign ch1_supply_evt = s_ch_low[0] || (channel_combine && s_ch_low[1]);
  assign ch2_supply_evt = channel_combine ? s_mismatch : s_ch_low[1];

  // fault_status_a layout
  assign set_a[lcs_pkg::FA_RAM_READY] = 1'b0;
  assign set_a[lcs_pkg::FA_MAIN_DROPOUT] = s_main_low || standby_exit;
  assign set_a[lcs_pkg::FA_RAM_CHECK] = ram_check_fault;
  assign set_a[lcs_pkg::FA_OVERHEAT] = s_heat;
  assign set_a[lcs_pkg::FA_CH2_OVC] = ovc_event[1];
  assign set_a[lcs_pkg::FA_CH1_OVC] = ovc_event[0];
  assign set_a[lcs_pkg::FA_OSC] = s_osc;
  assign set_a[lcs_pkg::FA_SETUP_TIMEOUT] = setup_timeout;

  // channel_status_b layout, channel 2 one stride up
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_stb
      localparam int B = gi * lcs_pkg::CH_STRIDE;
      assign set_b[B + lcs_pkg::CB_LOOP_STATE] = 1'b0;
      assign set_b[B + lcs_pkg::CB_MONITOR_SEEN] = monitor_enabled[gi];
      assign set_b[B + lcs_pkg::CB_HEADROOM] = s_headroom[gi];
      assign set_b[B + lcs_pkg::CB_SUPPLY_DROPOUT] = (gi == 0) ? ch1_supply_evt : ch2_supply_evt;
      // current state is live, not latched
      assign keep_b[B + lcs_pkg::CB_LOOP_STATE] = 1'b0;
      assign keep_b[B + lcs_pkg::CB_MONITOR_SEEN] = 1'b1;
      assign keep_b[B + lcs_pkg::CB_HEADROOM] = 1'b1;
      assign keep_b[B + lcs_pkg::CB_SUPPLY_DROPOUT] = 1'b1;
    end
  endgenerate

  // read clears the register, a concurrent event survives
  assign next_a = (read_a ? 8'h00 : fault_a_r) | set_a;
  assign next_b = ((read_b ? 8'h00 : chan_b_r) & keep_b) | set_b |
                  {3'h0, loop_state_in[1], 3'h0, loop_state_in[0]};

  // ==========
  // status registers, power-on values set the dropout and ram flags
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      fault_a_r <= lcs_pkg::RST_FAULT_A;
      chan_b_r <= lcs_pkg::RST_CHAN_B;
    end
    else
    begin
      fault_a_r <= next_a;
      chan_b_r <= next_b;
    end
  end

  // ==========
  // configuration writes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ch_ctrl_r[0] <= lcs_pkg::RST_CTRL;  // pulse bit resets zero
      ch_ctrl_r[1] <= lcs_pkg::RST_CTRL;
      combine_r <= lcs_pkg::RST_COMBINE;
      masks_r <= lcs_pkg::RST_MASKS;      // headroom masks reset to one
      range_r <= lcs_pkg::RST_RANGE;
    end
    else if (reg_wr)
    begin
      if (hit_c1)
        ch_ctrl_r[0] <= reg_wdata;
      else if (hit_c2)
        ch_ctrl_r[1] <= reg_wdata;
      else if (hit_comb)
        combine_r <= reg_wdata;
      else if (hit_mask)
        masks_r <= reg_wdata;
      else if (hit_rng)
        range_r <= reg_wdata;
    end
  end

  // off bits sit in bit 0 of each control register, one at reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      off_bits_r <= lcs_pkg::RST_OFF_BITS;
    else if (reg_wr && hit_c1)
      off_bits_r[0] <= reg_wdata[0];
    else if (reg_wr && hit_c2)
      off_bits_r[1] <= reg_wdata[0];
  end

  // ==========
  // register read mux; unmapped reads return zero
  logic [7:0] rdata_nxt;
  assign rdata_nxt = hit_a ? fault_a_r :
                     hit_b ? chan_b_r :
                     hit_c1 ? {ch_ctrl_r[0][7:1], off_bits_r[0]} :
                     hit_c2 ? {ch_ctrl_r[1][7:1], off_bits_r[1]} :
                     hit_comb ? combine_r :
                     hit_mask ? masks_r :
                     hit_rng ? range_r : 8'h00;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

  // ==========
  // field extraction
  assign ch1_headroom_select = ch_ctrl_r[0][lcs_pkg::CTRL_HEADROOM_LSB +: 2];
  assign ch2_headroom_select = ch_ctrl_r[1][lcs_pkg::CTRL_HEADROOM_LSB +: 2];
  assign pulse_enable = {ch_ctrl_r[1][lcs_pkg::CTRL_PULSE], ch_ctrl_r[0][lcs_pkg::CTRL_PULSE]};
  assign channel_combine = combine_r[lcs_pkg::COMBINE_BIT];
  assign ch1_range_factor = range_r[lcs_pkg::RANGE_CH1_LSB +: 2];
  assign ch2_range_factor = range_r[lcs_pkg::RANGE_CH2_LSB +: 2];
  // combined range: the two codes are summed for the mirror select
  assign combined_range_sel = channel_combine ? ({1'b0, ch1_range_factor} + {1'b0, ch2_range_factor})
                                              : {1'b0, ch1_range_factor};

  // ==========
  // pulsed optical power loop pause timers
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pause
      lcs_pause_timer #(.PAUSE_CYCLES(PAUSE_CYCLES)) u_pause (
        .clk(clk),
        .reset_n(reset_n),
        .armed(pulse_enable[gi] && !current_loop_select[gi]),  // none in current loop
        .gate_on(s_gate[gi]),
        .timed_out(apc_timeout[gi])
      );
    end
  endgenerate

  // ==========
  // channel enable logic
  logic any_pending;
  logic pin_open;
  logic hard_fault;
  logic [1:0] ch_allowed;
  assign any_pending = (|fault_a_r) || (|(chan_b_r & ~8'h33));  // pending status errors
  assign pin_open = s_ins_open || s_mode_open;
  // forced off regardless of ack
  assign hard_fault = s_heat || ram_check_fault || setup_timeout || (|ovc_event);
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_en
      assign ch_allowed[gi] = !off_bits_r[gi] && !any_pending && !pin_open && !hard_fault;
    end
  endgenerate

  // combined mode needs both channels allowed; channel 2 only parallels
  logic [1:0] en_nxt;
  assign en_nxt[0] = channel_combine ? (&ch_allowed) : ch_allowed[0];
  assign en_nxt[1] = channel_combine ? (&ch_allowed) : ch_allowed[1];

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      laser_enable <= 2'h0;
      current_on <= 2'h0;
      regulation_hold <= 2'h0;
    end
    else
    begin
      laser_enable <= en_nxt;
      // pulsed: gate pin switches current, regulator holds point
      current_on <= en_nxt & s_gate;
      regulation_hold <= pulse_enable & ~s_gate & ~apc_timeout;
    end
  end

  // ==========
  // error pin: any unmasked flag newly set or standing
  logic [7:0] mask_a;
  logic [7:0] mask_b;
  assign mask_a = {1'b0, masks_r[lcs_pkg::MASK_OSC], 6'h00};
  assign mask_b = {1'b0, masks_r[lcs_pkg::MASK_CH2_HEADROOM], 3'h0, masks_r[lcs_pkg::MASK_CH1_HEADROOM], 2'h0};
  logic fault_pin_nxt_w;
  // live loop state bits never flag the pin
  assign fault_pin_nxt_w = (|(next_a & ~mask_a)) || (|(next_b & ~mask_b & ~8'h11));

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      fault_pin_r <= 1'b1;
    else
      fault_pin_r <= fault_pin_nxt_w;
  end
  assign fault_out_pin_n = !fault_pin_r;
endmodule

// File: test/lcs_top_monitor.sv
// port-level checker for the laser channel safety control
`timescale 1ns/100ps
// ==========
// checker
module lcs_top_monitor #(
  parameter int PAUSE_CYCLES = lcs_pkg::APC_PAUSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic overheat_cmp,
  input wire logic interface_pin_open_fault,
  input wire logic mode_pin_open_fault,
  input wire logic [1:0] reference_curve_select,
  input wire logic fault_out_pin_n,
  input wire logic [1:0] ch1_headroom_select,
  input wire logic [1:0] laser_enable,
  input wire logic [1:0] overcurrent_active,
  input wire logic channel_combine,
  input wire logic [1:0] ch1_range_factor,
  input wire logic [1:0] ch2_range_factor,
  input wire logic [2:0] combined_range_sel
);
  // single clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // power-on flags leave the pin asserted and channels off
  property p_power_on;
    $rose(reset_n) |-> !fault_out_pin_n && laser_enable == 2'h0;
  endproperty
  a_power_on: assert property (p_power_on) else $error("pin or channel wrong after reset");
  // open pin, after the two-flop sync
  property p_open_pin_off;
    (interface_pin_open_fault || mode_pin_open_fault) [*5] |-> laser_enable == 2'h0;
  endproperty
  a_open_pin_off: assert property (p_open_pin_off) else $error("channel on with open pin");
  // heat fault forces both channels off
  property p_heat_off;
    overheat_cmp [*6] |-> laser_enable == 2'h0;
  endproperty
  a_heat_off: assert property (p_heat_off) else $error("channel on during overheat");
  // a signalled error keeps channels off
  property p_pending_off;
    !fault_out_pin_n [*2] |-> laser_enable == 2'h0;
  endproperty
  a_pending_off: assert property (p_pending_off) else $error("channel on with error pending");
  // combined channels switch together
  property p_combine_pair;
    channel_combine [*2] |-> laser_enable[0] == laser_enable[1];
  endproperty
  a_combine_pair: assert property (p_combine_pair) else $error("combined channels differ");
  // combined range is the sum of both codes
  property p_range_sum;
    channel_combine |-> combined_range_sel == {1'b0, ch1_range_factor} + {1'b0, ch2_range_factor};
  endproperty
  a_range_sum: assert property (p_range_sum) else $error("combined range not the sum");
  // headroom code written lands on the comparator select
  property p_headroom_wr;
    reg_wr && reg_addr == lcs_pkg::ADDR_CH1_CTRL |=> ch1_headroom_select == $past(reg_wdata[3:2]);
  endproperty
  a_headroom_wr: assert property (p_headroom_wr) else $error("headroom select not updated");
  // linear reference curve kills overcurrent detection
  property p_linear_no_ovc;
    reference_curve_select[0] [*2] |-> !overcurrent_active[0];
  endproperty
  a_linear_no_ovc: assert property (p_linear_no_ovc) else $error("overcurrent active on linear curve");
endmodule

bind lcs_top lcs_top_monitor #(.PAUSE_CYCLES(PAUSE_CYCLES)) i_mon (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .overheat_cmp(overheat_cmp), .interface_pin_open_fault(interface_pin_open_fault),
  .mode_pin_open_fault(mode_pin_open_fault), .reference_curve_select(reference_curve_select),
  .fault_out_pin_n(fault_out_pin_n), .ch1_headroom_select(ch1_headroom_select),
  .laser_enable(laser_enable), .overcurrent_active(overcurrent_active),
  .channel_combine(channel_combine), .ch1_range_factor(ch1_range_factor),
  .ch2_range_factor(ch2_range_factor), .combined_range_sel(combined_range_sel)
);

// File: test/lcs_host_model.sv
// host controller model driving the register port
`timescale 1ns/100ps
// ==========
// host model
module lcs_host_model (
  input wire logic clk,
  output logic [5:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle port at time zero
  initial
  begin
    reg_addr = 6'h3f;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // write: strobe up for exactly one taking edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // released data shows the inverse, never a stale copy
    reg_wdata <= ~d;
  endtask
  // read: registered answer, taken a cycle later
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // read both status registers to acknowledge
  task automatic ack_all(output logic [7:0] sa, output logic [7:0] sb);
    rd(6'h00, sa);
    rd(6'h01, sb);
  endtask
  // combine: set merge bit, clear both off bits
  task automatic combine;
    wr(6'h1b, 8'h40);
    wr(6'h13, 8'h00);
    wr(6'h18, 8'h00);
  endtask
endmodule

// File: test/lcs_top_test.sv
// self-checking testbench for the laser channel safety control
`timescale 1ns/100ps
module lcs_top_test;
  // ==========
  // signals
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [13:0] ev = '0; // event sources
  logic [1:0] gate = 2'h3;
  logic [1:0] opn = 2'h0; // open select pin, open mode pin
  logic [1:0] loop_sel = 2'h0;
  logic [1:0] lim0 = 2'h0;
  logic [1:0] curve = 2'h0;
  logic [5:0] reg_addr;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic fault_out_pin_n;
  logic [1:0] ch1_headroom_select;
  logic [1:0] ch2_headroom_select;
  logic [1:0] laser_enable;
  logic [1:0] current_on;
  logic [1:0] regulation_hold;
  logic [1:0] overcurrent_active;
  logic channel_combine;
  logic [1:0] ch1_range_factor;
  logic [1:0] ch2_range_factor;
  logic [2:0] combined_range_sel;
  int n_mismatch = 0;
  int check_count = 0;
  // flag bit per event; first ten in status a
  int fb[14] = '{3, 5, 4, 2, 7, 6, 1, 1, 5, 4, 2, 6, 3, 7};
  logic [7:0] mk[2] = '{8'h0c, 8'h01};
  logic [3:0] cs[6] = '{4'h8, 4'ha, 4'hc, 4'h9, 4'h4, 4'h0}; // pulse, loop, zero limit, curve
  logic [5:0] ra[6] = '{6'h1d, 6'h1b, 6'h1e, 6'h3f, 6'h13, 6'h18};
  logic [7:0] re[6] = '{8'h0c, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
  logic [7:0] sa;
  logic [7:0] sb;
  logic [7:0] d;
  logic msk;
  logic ex;
  // 50 MHz clock
  always #10 clk = ~clk;
  // ==========
  // design and host
  lcs_top #(.PAUSE_CYCLES(20)) i_dut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .headroom_cmp(ev[11:10]), .overcurrent_cmp(ev[2:1]),
    .overheat_cmp(ev[0]), .main_supply_low(ev[7]), .channel_supply_low(ev[13:12]), .supply_mismatch(1'b0),
    .osc_watchdog_fail(ev[5]), .interface_pin_open_fault(opn[0]), .mode_pin_open_fault(opn[1]),
    .channel_gate_pin(gate), .ram_check_fault(ev[3]), .setup_timeout(ev[4]), .standby_exit(ev[6]),
    .loop_state_in(2'h3), .monitor_enabled(2'h0), .current_loop_select(loop_sel), .ch_limit_zero(lim0),
    .reference_curve_select(curve), .simulate_overcurrent(ev[9:8]), .fault_out_pin_n(fault_out_pin_n),
    .ch1_headroom_select(ch1_headroom_select), .ch2_headroom_select(ch2_headroom_select),
    .laser_enable(laser_enable), .current_on(current_on), .regulation_hold(regulation_hold),
    .overcurrent_active(overcurrent_active), .channel_combine(channel_combine), .ch1_range_factor(ch1_range_factor),
    .ch2_range_factor(ch2_range_factor), .combined_range_sel(combined_range_sel)
  );
  lcs_host_model i_host (
    .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );
  // ==========
  // helpers
  // n edges, then past their updates
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_test(input string nm);
    $display("test %s done, %0d mismatches", nm, n_mismatch);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole run needs far fewer cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  // ==========
  // tests
  initial
  begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    wt(2);
    chk("pin after reset", 8'h00, fault_out_pin_n);
    i_host.ack_all(sa, sb);
    chk("status a at power-on", 8'h03, sa);
    chk("status b at power-on", 8'h99, sb);
    // reset values, off bits included
    foreach (ra[i])
    begin
      i_host.rd(ra[i], d);
      chk("reset value", re[i], d);
    end
    i_host.wr(6'h00, 8'hff);
    i_host.rd(6'h00, d);
    chk("status a after write", 8'h00, d);
    wt(4);
    chk("pin after ack", 8'h01, fault_out_pin_n);
    chk("enable with off bits", 8'h00, laser_enable);
    i_host.wr(6'h13, 8'h00);
    wt(6);
    chk("ch1 only enabled", 8'h01, laser_enable);
    end_test("reset");
    // each event under both mask sets
    foreach (mk[p])
    begin
      i_host.wr(6'h1d, mk[p]);
      for (int i = 0; i < 14; i++)
      begin
        @(posedge clk);
        ev[i] <= 1'b1;
        wt(6);
        chk("enable during event", 8'h00, laser_enable);
        @(posedge clk);
        ev[i] <= 1'b0;
        wt(6);
        msk = (i == 5) ? mk[p][0] : (i == 10) ? mk[p][2] : (i == 11) ? mk[p][3] : 1'b0;
        chk("error pin", {7'h00, msk}, fault_out_pin_n);
        i_host.rd(i < 10 ? 6'h00 : 6'h01, d);
        chk("status flag", (8'h01 << fb[i]) | (i < 10 ? 8'h00 : 8'h11), d);
        wt(6);
        chk("enable after ack", 8'h01, laser_enable);
        chk("pin after ack", 8'h01, fault_out_pin_n);
      end
    end
    end_test("events");
    for (int k = 0; k < 4; k++)
    begin
      i_host.wr(6'h13, 8'(k << 2));
      i_host.wr(6'h18, 8'(k << 2) | 8'h01);
      wt(1);
      chk("ch1 headroom code", 8'(k), ch1_headroom_select);
      chk("ch2 headroom code", 8'(k), ch2_headroom_select);
    end
    // overcurrent detection against pulse, loop, limit and curve
    foreach (cs[j])
    begin
      i_host.wr(6'h13, {cs[j][3], 7'h00});
      i_host.wr(6'h18, {cs[j][3], 7'h01});
      @(posedge clk);
      loop_sel <= {2{cs[j][2]}};
      lim0 <= {2{cs[j][1]}};
      curve <= {2{cs[j][0]}};
      wt(4);
      i_host.rd(6'h13, d);
      chk("pulse bit", {cs[j][3], 7'h00}, d & 8'h80);
      ex = !cs[j][0] && !(cs[j][3] && (cs[j][2] || cs[j][1]));
      chk("overcurrent active", {6'h00, ex, ex}, overcurrent_active);
    end
    end_test("codes");
    i_host.combine();
    for (int k = 0; k < 4; k++)
    begin
      i_host.wr(6'h1e, {2'h0, 2'(k ^ 1), 2'h0, 2'(k)});
      wt(2);
      chk("ch1 range", 8'(k), ch1_range_factor);
      chk("ch2 range", 8'(k ^ 1), ch2_range_factor);
      chk("combined range", 8'(k + (k ^ 1)), combined_range_sel);
    end
    wt(6);
    chk("combine flag", 8'h01, channel_combine);
    chk("both channels on", 8'h03, laser_enable);
    @(posedge clk);
    gate <= 2'h1;
    wt(8);
    chk("combined gate low", 8'h03, laser_enable);
    chk("combined current", 8'h01, current_on);
    @(posedge clk);
    gate <= 2'h3;
    // open select pin, then open mode pin
    for (int q = 0; q < 2; q++)
    begin
      @(posedge clk);
      opn <= 2'h1 << q;
      wt(8);
      chk("enable with open pin", 8'h00, laser_enable);
      @(posedge clk);
      opn <= 2'h0;
      wt(8);
    end
    // pulsed: power loop times out, current loop never
    i_host.wr(6'h13, 8'h80);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      loop_sel <= 2'(m);
      gate <= 2'h2;
      wt(8);
      chk("hold", 8'h01, regulation_hold);
      wt(20);
      chk("hold timeout", 8'(m), regulation_hold);
      @(posedge clk);
      gate <= 2'h3;
    end
    end_test("combine");
    finish_test();
  end
endmodule
